// *** src/running_status_word_display.v ***
`timescale 1ns/100ps
`include "status_display_consts.vh"

module running_status_word_display (
	// Clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Drive state flags
	input  wire        code_write_busy,
	input  wire        link_run_permit,
	input  wire        alarm_flag,
	input  wire        slowing_down,
	input  wire        speeding_up,
	input  wire        current_limiting,
	input  wire        voltage_limiting,
	input  wire        torque_limiting,
	input  wire        bus_voltage_ok,
	input  wire        braking_active,
	input  wire        output_shutdown,
	input  wire        dc_braking,
	input  wire        backward_run,
	input  wire        forward_run,
	// Terminal and encoder sources
	input  wire [15:0] terminal_bits,
	input  wire [15:0] link_terminal_bits,
	input  wire [16:0] pg_pulse_rate,
	// Keypad, one-cycle pulses
	input  wire        key_prog,
	input  wire        key_up,
	input  wire        key_down,
	input  wire        key_enter,
	input  wire        key_return,
	// LED monitor, leftmost digit first, segments g..a
	output reg  [6:0]  led4_seg,
	output reg  [6:0]  led3_seg,
	output reg  [6:0]  led2_seg,
	output reg  [6:0]  led1_seg,
	// Interrupt
	output wire        irq
);

	localparam [4:0] ST_RUN  = 5'h01;
	localparam [4:0] ST_FUNC = 5'h02;
	localparam [4:0] ST_LIST = 5'h04;
	localparam [4:0] ST_DATA = 5'h08;
	localparam [4:0] ST_IDLE = 5'h10;

	reg  [4:0]  state_q;
	reg  [4:0]  state_d;
	reg  [1:0]  func_q;
	reg  [3:0]  item_q;
	reg  [31:0] ctrl_q;
	reg  [`EVT_WIDTH-1:0] evt_q;
	reg  [`EVT_WIDTH-1:0] mask_q;
	reg  [15:0] status_q;
	reg  [15:0] shown_q;
	reg         seg_view_q;
	reg  [16:0] pg_quot_q;
	reg  [15:0] shown_d;
	reg  [1:0]  func_d;
	reg  [3:0]  item_d;
	reg         seg_view_d;
	reg  [31:0] ctrl_d;
	reg  [`EVT_WIDTH-1:0] evt_d;
	reg  [`EVT_WIDTH-1:0] mask_d;
	reg  [31:0] rdata_d;
	reg  [6:0]  led4_d;
	reg  [6:0]  led3_d;
	reg  [6:0]  led2_d;
	reg  [6:0]  led1_d;
	wire [15:0] status_d;
	wire [16:0] pg_quot_d;
	wire        wr;
	wire        rd_setup;
	wire        acc_done;
	wire        full_menu;
	wire        sel_status;
	wire        sel_ctrl;
	wire        sel_evt;
	wire        sel_mask;
	wire        sel_shown;
	wire        sel_keys;
	wire        term_item;
	wire        seg_mode;
	wire        alarm_rise;
	wire        busy_fall;
	wire        bus_drop;
	wire [`EVT_WIDTH-1:0] evt_set;

	assign status_d = {code_write_busy, 2'h0, link_run_permit,
			   alarm_flag,
			   slowing_down, speeding_up, current_limiting,
			   voltage_limiting,
			   torque_limiting,
			   bus_voltage_ok,
			   braking_active, output_shutdown, dc_braking,
			   backward_run,
			   forward_run};

	assign wr        = psel & penable & pwrite;
	assign rd_setup  = psel & ~penable & ~pwrite;
	assign acc_done  = psel & penable;
	assign pready    = 1'b1;
	assign pslverr   = 1'b0;
	assign full_menu = (ctrl_q[`CTRL_LEVEL_MSB:`CTRL_LEVEL_LSB] == `MENU_FULL);

	// Full compare of the offset; aliases would hide software bugs
	assign sel_status = (paddr == `REG_STATUS_WORD);
	assign sel_ctrl   = (paddr == `REG_CTRL);
	assign sel_evt    = (paddr == `REG_EVT_STATUS);
	assign sel_mask   = (paddr == `REG_EVT_MASK);
	assign sel_shown  = (paddr == `REG_DISPLAY);
	assign sel_keys   = (paddr == `REG_KEYS);

	// Only the two digital terminal items offer the segment view
	assign term_item = (func_q == `FUNC_IO_CHECK) &&
			   (item_q == `ITEM_TERM || item_q == `ITEM_TERM_LINK);
	assign seg_mode  = (state_q == ST_DATA) && term_item && seg_view_q;

	// Edges only, alarm rising, busy and bus ok falling; a level would refire after each clear
	assign alarm_rise = status_d[`BIT_ALARM] & ~status_q[`BIT_ALARM];
	assign busy_fall  = ~status_d[`BIT_BUSY] & status_q[`BIT_BUSY];
	assign bus_drop   = ~status_d[`BIT_BUS_OK] & status_q[`BIT_BUS_OK];
	assign evt_set[`EVT_ALARM]     = alarm_rise;
	assign evt_set[`EVT_BUSY_DONE] = busy_fall;
	assign evt_set[`EVT_UNDERVOLT] = bus_drop;
	assign irq = |(evt_q & mask_q);

	// Hex glyph, segments g..a
	function [6:0] hex_glyph;
		input [3:0] n;
		begin
			case (n)
			4'h0: hex_glyph = 7'h3F;
			4'h1: hex_glyph = 7'h06;
			4'h2: hex_glyph = 7'h5B;
			4'h3: hex_glyph = 7'h4F;
			4'h4: hex_glyph = 7'h66;
			4'h5: hex_glyph = 7'h6D;
			4'h6: hex_glyph = 7'h7D;
			4'h7: hex_glyph = 7'h07;
			4'h8: hex_glyph = 7'h7F;
			4'h9: hex_glyph = 7'h6F;
			4'hA: hex_glyph = 7'h77;
			4'hB: hex_glyph = 7'h7C;
			4'hC: hex_glyph = 7'h58;
			4'hD: hex_glyph = 7'h5E;
			4'hE: hex_glyph = 7'h79;
			default: hex_glyph = 7'h71;
			endcase
		end
	endfunction

	// Register next values
	always @* begin
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		// Set wins over write-one clear
		evt_d  = evt_q | evt_set;
		if (wr && sel_ctrl) begin
			ctrl_d = pwdata & 32'h0000_0007;
		end
		if (wr && sel_mask) begin
			mask_d = pwdata[`EVT_WIDTH-1:0];
		end
		if (wr && sel_evt) begin
			evt_d = (evt_q & ~pwdata[`EVT_WIDTH-1:0]) | evt_set;
		end
	end

	// Register file
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `CTRL_RESET;
			evt_q  <= {`EVT_WIDTH{1'b0}};
			mask_q <= {`EVT_WIDTH{1'b0}};
		end else begin
			ctrl_q <= ctrl_d;
			evt_q  <= evt_d;
			mask_q <= mask_d;
		end
	end

	// Read data captured in the setup phase so it stands through access
	always @* begin
		rdata_d = 32'h0000_0000;
		if (sel_status) begin
			rdata_d = {16'h0000, status_d};
		end else if (sel_ctrl) begin
			rdata_d = ctrl_q;
		end else if (sel_evt) begin
			rdata_d = {{(32-`EVT_WIDTH){1'b0}}, evt_q};
		end else if (sel_mask) begin
			rdata_d = {{(32-`EVT_WIDTH){1'b0}}, mask_q};
		end else if (sel_shown) begin
			rdata_d = {16'h0000, shown_q};
		end else if (sel_keys) begin
			rdata_d = {19'h00000, seg_view_q, item_q, func_q, 1'b0, state_q};
		end
	end

	// Zero outside a read keeps stale data off the bus
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= rdata_d;
		end else if (acc_done) begin
			prdata <= 32'h0000_0000;
		end
	end

	// Keypad menu machine
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_RUN: begin
			if (key_prog) begin
				state_d = ST_FUNC;
			end
		end
		ST_FUNC: begin
			// Entering the list needs the full menu level
			if (key_enter && full_menu) begin
				state_d = ST_LIST;
			end else if (key_prog) begin
				state_d = ST_RUN;
			end
		end
		ST_LIST: begin
			if (key_return) begin
				state_d = ST_FUNC;
			end else if (key_enter) begin
				state_d = ST_DATA;
			end
		end
		ST_DATA: begin
			if (key_return) begin
				state_d = ST_LIST;
			end
		end
		ST_IDLE: begin
			state_d = ST_RUN;
		end
		default: begin
			state_d = ST_RUN;
		end
		endcase
	end

	// Keypad selections, next values
	always @* begin
		func_d     = func_q;
		item_d     = item_q;
		seg_view_d = seg_view_q;
		if (state_q == ST_FUNC && (key_up || key_down)) begin
			func_d = func_q ^ 2'h1;
		end
		if (state_q == ST_LIST) begin
			if (key_up) begin
				item_d = item_q + 4'h1;
			end else if (key_down) begin
				item_d = item_q - 4'h1;
			end
		end
		// Up and down only flip the view; the item itself stays put
		if (state_q == ST_DATA && term_item && (key_up || key_down)) begin
			seg_view_d = ~seg_view_q;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q    <= ST_RUN;
			func_q     <= `FUNC_DRIVE_MON;
			item_q     <= `ITEM_STATUS;
			seg_view_q <= 1'b1;
		end else begin
			state_q    <= state_d;
			func_q     <= func_d;
			item_q     <= item_d;
			seg_view_q <= seg_view_d;
		end
	end

	// Display data path
	always @* begin
		shown_d = shown_q;
		if (state_q == ST_DATA) begin
			if (func_q == `FUNC_DRIVE_MON) begin
				if (item_q == `ITEM_STATUS) begin
					shown_d = status_q;
				end else begin
					shown_d = 16'h0000;
				end
			end else begin
				case (item_q)
				`ITEM_TERM:      shown_d = terminal_bits;
				`ITEM_TERM_LINK: shown_d = link_terminal_bits;
				`ITEM_PG_RATE:   shown_d = pg_quot_q[15:0];
				default:         shown_d = 16'h0000;
				endcase
			end
		end
	end

	// Divide by a constant; rate fits 17 bits so quotient fits 8
	assign pg_quot_d = pg_pulse_rate / `PG_DIVISOR;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_q  <= 16'h0000;
			shown_q   <= 16'h0000;
			pg_quot_q <= 17'h00000;
		end else begin
			status_q  <= status_d;
			shown_q   <= shown_d;
			pg_quot_q <= pg_quot_d;
		end
	end

	// LED drive; segment view maps terminal bits straight to segments
	always @* begin
		led4_d = hex_glyph(shown_d[15:12]);
		led3_d = hex_glyph(shown_d[11:8]);
		led2_d = hex_glyph(shown_d[7:4]);
		led1_d = hex_glyph(shown_d[3:0]);
		if (seg_mode) begin
			led4_d = {6'h00, shown_d[8]};
			led3_d = {5'h00, shown_d[1:0]};
			led2_d = 7'h00;
			led1_d = shown_d[6:0];
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led4_seg <= 7'h00;
			led3_seg <= 7'h00;
			led2_seg <= 7'h00;
			led1_seg <= 7'h00;
		end else begin
			led4_seg <= led4_d;
			led3_seg <= led3_d;
			led2_seg <= led2_d;
			led1_seg <= led1_d;
		end
	end

endmodule

// *** shared/status_display_consts.vh ***
`ifndef STATUS_DISPLAY_CONSTS_VH
`define STATUS_DISPLAY_CONSTS_VH

// Register byte offsets
`define REG_STATUS_WORD   12'h000
`define REG_CTRL          12'h004
`define REG_EVT_STATUS    12'h008
`define REG_EVT_MASK      12'h00C
`define REG_DISPLAY       12'h010
`define REG_KEYS          12'h014

// Status word bit positions
`define BIT_BUSY          15
`define BIT_LINK_RUN      12
`define BIT_ALARM         11
`define BIT_SLOWING       10
`define BIT_SPEEDING      9
`define BIT_CUR_LIM       8
`define BIT_VOLT_LIM      7
`define BIT_TORQ_LIM      6
`define BIT_BUS_OK        5
`define BIT_BRAKING       4
`define BIT_SHUTDOWN      3
`define BIT_DC_BRAKE      2
`define BIT_BACKWARD      1
`define BIT_FORWARD       0

// Control register fields
`define CTRL_LEVEL_LSB    0
`define CTRL_LEVEL_MSB    1
`define CTRL_HEXMODE      2
`define CTRL_RESET        32'h0000_0000
`define MENU_FULL         2'h2

// Menu and item codes
`define FUNC_DRIVE_MON    2'h0
`define FUNC_IO_CHECK     2'h1
`define ITEM_STATUS       4'h7
`define ITEM_TERM         4'h0
`define ITEM_TERM_LINK    4'h1
`define ITEM_PG_RATE      4'hF

// Event bits
`define EVT_ALARM         0
`define EVT_BUSY_DONE     1
`define EVT_UNDERVOLT     2
`define EVT_WIDTH         3

// Pulse rate scaling
`define PG_DIVISOR        17'h003E8

`endif

// *** tb/keypad_model.sv ***
`timescale 1ns/100ps
module keypad_model (
	// Clock
	input  wire       pclk,
	// Keys: prog, up, down, enter, return
	output reg  [4:0] keys
);
	initial keys = 5'h00;
	// Gap after each press so the menu settles first
	task automatic press(input int k, input int n);
		repeat (n) begin
			@(posedge pclk) keys[k] <= 1'b1;
			@(posedge pclk) keys[k] <= 1'b0;
			repeat (3) @(posedge pclk);
		end
	endtask
endmodule

// *** tb/running_status_word_display_properties.sv ***
`timescale 1ns/100ps
module status_word_checker (
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        code_write_busy,
	input wire        link_run_permit,
	input wire        alarm_flag,
	input wire        slowing_down,
	input wire        voltage_limiting,
	input wire        torque_limiting,
	input wire        bus_voltage_ok,
	input wire        dc_braking,
	input wire        forward_run
);
	logic up_q;
	// Skip the first edge, status is still the reset image
	wire  rd = up_q && psel && penable && !pwrite && paddr == 12'h000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_q <= 1'b0;
		else
			up_q <= 1'b1;
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_busy; rd |-> prdata[15] == $past(code_write_busy); endproperty
	a_busy: assert property (p_busy) else $error("busy bit wrong");
	property p_zero; rd |-> prdata[14:13] == 2'b00; endproperty
	a_zero: assert property (p_zero) else $error("reserved bits set");
	property p_link; rd |-> prdata[12] == $past(link_run_permit); endproperty
	a_link: assert property (p_link) else $error("link bit wrong");
	property p_alarm; rd |-> prdata[11] == $past(alarm_flag); endproperty
	a_alarm: assert property (p_alarm) else $error("alarm bit wrong");
	property p_slow; rd |-> prdata[10] == $past(slowing_down); endproperty
	a_slow: assert property (p_slow) else $error("slowing bit wrong");
	property p_volt; rd |-> prdata[7] == $past(voltage_limiting); endproperty
	a_volt: assert property (p_volt) else $error("voltage bit wrong");
	property p_torq; rd |-> prdata[6] == $past(torque_limiting); endproperty
	a_torq: assert property (p_torq) else $error("torque bit wrong");
	property p_bus; rd |-> prdata[5] == $past(bus_voltage_ok); endproperty
	a_bus: assert property (p_bus) else $error("bus ok bit wrong");
	property p_dcb; rd |-> prdata[2] == $past(dc_braking); endproperty
	a_dcb: assert property (p_dcb) else $error("dc brake bit wrong");
	property p_fwd; rd |-> prdata[0] == $past(forward_run); endproperty
	a_fwd: assert property (p_fwd) else $error("forward bit wrong");
	c_busy: cover property (rd && prdata[15]);
	c_alarm: cover property (rd && prdata[11]);
	c_fwd: cover property (rd && prdata[0]);
endmodule
bind running_status_word_display status_word_checker u_chk (.*);

// *** tb/running_status_word_display_tb.sv ***
`timescale 1ns/100ps
module running_status_word_display_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] fl, tb_bits, lt_bits;
	logic [16:0] pg;
	logic [6:0] l4, l3, l2, l1;
	wire  [4:0] k;
	int n_errors, n_tests, cyc;
	logic [6:0] gl [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
		7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h58, 7'h5E, 7'h79, 7'h71};
	keypad_model kp (.pclk(pclk), .keys(k));
	running_status_word_display dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .code_write_busy(fl[15]), .link_run_permit(fl[12]), .alarm_flag(fl[11]),
		.slowing_down(fl[10]), .speeding_up(fl[9]), .current_limiting(fl[8]), .voltage_limiting(fl[7]),
		.torque_limiting(fl[6]), .bus_voltage_ok(fl[5]), .braking_active(fl[4]), .output_shutdown(fl[3]),
		.dc_braking(fl[2]), .backward_run(fl[1]), .forward_run(fl[0]), .terminal_bits(tb_bits),
		.link_terminal_bits(lt_bits), .pg_pulse_rate(pg), .key_prog(k[0]), .key_up(k[1]),
		.key_down(k[2]), .key_enter(k[3]), .key_return(k[4]), .led4_seg(l4), .led3_seg(l3),
		.led2_seg(l2), .led1_seg(l1), .irq(irq));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		r = prdata;
		chk("pslverr", 32'h0, pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Leds lag a change by two edges, three give margin
	task automatic leds(input logic [15:0] v);
		repeat (3) @(posedge pclk);
		#1 chk("leds", {gl[v[15:12]], gl[v[11:8]], gl[v[7:4]], gl[v[3:0]]}, {l4, l3, l2, l1});
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			end_sim;
		end
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, fl, tb_bits, lt_bits, pg} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		leds(16'h0000);
		apb(0, 12'h004, 0);
		chk("ctrl", 32'h0, r);
		apb(0, 12'h018, 0);
		chk("unmapped", 32'h0, r);
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk) fl <= 16'h1 << i;
			apb(0, 12'h000, 0);
			chk("status", (i == 13 || i == 14) ? 32'h0 : 32'h1 << i, r);
		end
		$display("status bits done");
		@(posedge pclk) fl <= 16'h8321;
		kp.press(0, 1);
		kp.press(3, 2);
		leds(16'h0000);
		apb(1, 12'h004, 32'h2);
		kp.press(3, 2);
		leds(16'h8321);
		@(posedge pclk) fl <= 16'h9CEF;
		leds(16'h9CEF);
		@(posedge pclk) fl <= 16'h8ABD;
		leds(16'h8ABD);
		$display("status display done");
		kp.press(4, 1);
		@(posedge pclk) fl <= 16'h0001;
		leds(16'h8ABD);
		kp.press(4, 1);
		kp.press(1, 1);
		kp.press(3, 1);
		kp.press(1, 8);
		@(posedge pclk) pg <= 17'd98765;
		kp.press(3, 1);
		leds(16'h0062);
		kp.press(4, 1);
		@(posedge pclk) tb_bits <= 16'h0105;
		kp.press(1, 1);
		kp.press(3, 1);
		repeat (3) @(posedge pclk);
		#1 chk("segments", {7'h01, 7'h01, 7'h00, 7'h05}, {l4, l3, l2, l1});
		kp.press(1, 1);
		leds(16'h0105);
		kp.press(4, 1);
		@(posedge pclk) lt_bits <= 16'h0A03;
		kp.press(1, 1);
		kp.press(3, 1);
		apb(0, 12'h010, 0);
		chk("shown", 32'h0A03, r);
		apb(0, 12'h014, 0);
		chk("keys", 32'h0000_0148, r);
		$display("menu done");
		apb(1, 12'h008, 32'h7);
		apb(1, 12'h00C, 32'h1);
		@(posedge pclk) fl <= 16'h0820;
		repeat (3) @(posedge pclk);
		chk("irq set", 32'h1, irq);
		@(posedge pclk) fl <= 16'h0000;
		apb(1, 12'h008, 32'h1);
		@(posedge pclk);
		chk("irq masked", 32'h0, irq);
		apb(0, 12'h008, 0);
		chk("events", 32'h4, r);
		apb(1, 12'h00C, 32'h4);
		@(posedge pclk);
		chk("irq unmask", 32'h1, irq);
		apb(1, 12'h008, 32'h4);
		@(posedge pclk);
		chk("irq clear", 32'h0, irq);
		$display("interrupt done");
		end_sim;
	end
endmodule
